//--- dv/dtcu_pin_model.sv
`timescale 1ns/1ns
// Far side of the pins: count sources, capture pin and comparator output
module dtcu_pin_model
(
  input wire logic pclk,
  output logic narrow_count_pin,
  output logic wide_count_pin,
  output logic capture_pin,
  output logic comparator_in
);
  logic [3:0] pins_q = 4'h0;
  assign narrow_count_pin = pins_q[0];
  assign wide_count_pin = pins_q[1];
  assign capture_pin = pins_q[2];
  assign comparator_in = pins_q[3];
  // Low phase is three clocks, high phase never below one clock
  task automatic pulse(input int sel, input int hi_cyc, input int num);
    for (int i = 0; i < num; i++)
    begin
      @(posedge pclk);
      pins_q[sel] <= 1'b1;
      repeat (hi_cyc) @(posedge pclk);
      pins_q[sel] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
endmodule : dtcu_pin_model

//--- dv/dtcu_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module dual_timer_counter_unit_tb_top
  import dtcu_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic narrow_count_pin;
  logic wide_count_pin;
  logic capture_pin;
  logic comparator_in;
  logic compare_a_out;
  logic compare_b_out;
  logic irq;
  logic [7:0] rd;
  logic err;
  int failures = 0;
  int checks_done = 0;

  dtcu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .narrow_count_pin(narrow_count_pin), .wide_count_pin(wide_count_pin),
    .capture_pin(capture_pin), .comparator_in(comparator_in),
    .compare_a_out(compare_a_out), .compare_b_out(compare_b_out),
    .irq(irq));
  dtcu_pin_model pin_u (.pclk(pclk), .narrow_count_pin(narrow_count_pin),
    .wide_count_pin(wide_count_pin), .capture_pin(capture_pin),
    .comparator_in(comparator_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task results();
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Request held until pready is seen high; only the watchdog ends a hang
  task automatic apb(input logic [5:0] idx, input logic wr_en,
    input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(idx, 1'b1, wd);
  endtask : wr

  task automatic rdr(input logic [5:0] idx);
    apb(idx, 1'b0, 8'h00);
  endtask : rdr

  task automatic t_regs();
    logic [5:0] ix [8];
    ix = '{IDX_CAP_LO, IDX_CAP_HI, IDX_CMPB_LO, IDX_CMPB_HI, IDX_CMPA_LO,
      IDX_CMPA_HI, IDX_FLAGS, IDX_NCNT};
    foreach (ix[i])
    begin
      rdr(ix[i]);
      `CHK(rd, RST_BYTE)
    end
    for (int i = 2; i < 6; i++)
    begin
      wr(ix[i], 8'hA0 + 8'(i));
      rdr(ix[i]);
      `CHK(rd, 8'hA0 + 8'(i))
    end
    wr(IDX_CAP_LO, 8'h77);
    rdr(IDX_CAP_LO);
    `CHK(rd, RST_BYTE)
    wr(IDX_MASK, 8'hFF);
    rdr(IDX_MASK);
    `CHK(rd, FLAG_USED)
    wr(IDX_MASK, 8'h00);
    wr(IDX_WCTL_A, 8'hF3);
    rdr(IDX_WCTL_A);
    `CHK(rd, 8'hF3)
    wr(IDX_WCTL_A, 8'h00);
    apb(6'h31, 1'b0, 8'h00);
    `CHK({err, rd}, 9'h100)
  endtask : t_regs

  task automatic t_ext();
    wr(IDX_NCTL, {5'h00, CS_EXT_RISE});
    pin_u.pulse(0, 2, 5);
    rdr(IDX_NCNT);
    `CHK(rd, 8'h05)
    wr(IDX_NCTL, {5'h00, CS_EXT_FALL});
    pin_u.pulse(0, 2, 3);
    repeat (4) @(posedge pclk);
    rdr(IDX_NCNT);
    `CHK(rd, 8'h08)
    wr(IDX_NCTL, {5'h00, CS_STOP});
    pin_u.pulse(0, 2, 2);
    rdr(IDX_NCNT);
    `CHK(rd, 8'h08)
    wr(IDX_WCTL_B, {5'h00, CS_EXT_RISE});
    pin_u.pulse(1, 1, 7);
    repeat (4) @(posedge pclk);
    rdr(IDX_WCNT_LO);
    `CHK(rd, 8'h07)
    wr(IDX_WCTL_B, 8'h00);
  endtask : t_ext

  // Both counters run at once on different taps of the one prescaler
  task automatic t_presc();
    logic [2:0] ncs [2];
    logic [2:0] wcs [2];
    int span [2];
    int ne [2];
    ncs = '{CS_DIV8, CS_DIV256};
    wcs = '{CS_DIV64, CS_DIV1024};
    span = '{768, 12288};
    ne = '{96, 48};
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_NCNT, 8'h00);
      wr(IDX_WCNT_LO, 8'h00);
      wr(IDX_NCTL, {5'h00, ncs[i]});
      wr(IDX_WCTL_B, {5'h00, wcs[i]});
      repeat (span[i]) @(posedge pclk);
      wr(IDX_NCTL, 8'h00);
      wr(IDX_WCTL_B, 8'h00);
      rdr(IDX_NCNT);
      `CHK(rd >= ne[i] - 1 && rd <= ne[i] + 1, 1'b1)
      rdr(IDX_WCNT_LO);
      `CHK(rd >= 11 && rd <= 13, 1'b1)
    end
  endtask : t_presc

  task automatic t_ovf();
    wr(IDX_NCNT, 8'hFE);
    wr(IDX_NCTL, {5'h00, CS_CLK});
    wr(IDX_NCTL, {5'h00, CS_STOP});
    rdr(IDX_FLAGS);
    `CHK(rd, 8'h02)
    `CHK(irq, 1'b0)
    wr(IDX_MASK, 8'hE8);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(IDX_MASK, 8'h02);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(IDX_FLAGS, 8'h02);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rdr(IDX_FLAGS);
    `CHK(rd, 8'h00)
    wr(IDX_MASK, 8'h00);
  endtask : t_ovf

  task automatic t_cmp();
    int chg;
    logic prev;
    wr(IDX_WCNT_LO, 8'h00);
    wr(IDX_CMPA_HI, 8'h00);
    wr(IDX_CMPA_LO, 8'h10);
    wr(IDX_CMPB_HI, 8'h00);
    wr(IDX_CMPB_LO, 8'h08);
    wr(IDX_FLAGS, 8'hFF);
    wr(IDX_WCTL_A, {ACT_TOGGLE, ACT_SET, 4'h0});
    wr(IDX_WCTL_B, {4'h0, 1'b1, CS_CLK});
    chg = 0;
    prev = compare_a_out;
    repeat (100)
    begin
      @(posedge pclk);
      if (compare_a_out !== prev)
        chg++;
      prev = compare_a_out;
    end
    wr(IDX_WCTL_B, 8'h08);
    `CHK(chg >= 5 && chg <= 6, 1'b1)
    `CHK(compare_b_out, 1'b1)
    rdr(IDX_FLAGS);
    `CHK(rd, 8'h60)
    rdr(IDX_WCNT_HI);
    `CHK(rd, 8'h00)
  endtask : t_cmp

  // Equal compares with opposite actions give complementary pin levels
  task automatic t_pwm();
    int per;
    int ah;
    int bh;
    wr(IDX_CMPA_LO, 8'h40);
    wr(IDX_CMPB_LO, 8'h40);
    for (int r = 1; r < 4; r++)
    begin
      per = 2 * ((256 << (r - 1)) - 1);
      ah = 0;
      bh = 0;
      wr(IDX_WCTL_A, {ACT_CLEAR, ACT_SET, 2'h0, 2'(r)});
      wr(IDX_WCTL_B, {5'h00, CS_CLK});
      repeat (per) @(posedge pclk);
      repeat (per)
      begin
        @(posedge pclk);
        ah += int'(compare_a_out === 1'b1);
        bh += int'(compare_b_out === 1'b1);
      end
      wr(IDX_WCTL_B, 8'h00);
      `CHK(ah >= 125 && ah <= 131, 1'b1)
      `CHK(ah + bh == per, 1'b1)
    end
    // Bottom of each PWM period raises the wide overflow flag
    rdr(IDX_FLAGS);
    `CHK(rd, 8'hE0)
    wr(IDX_WCTL_A, 8'h00);
  endtask : t_pwm

  task automatic t_cap();
    wr(IDX_WCNT_LO, 8'h00);
    wr(IDX_FLAGS, 8'hFF);
    wr(IDX_WCTL_B, {2'h1, 3'h0, CS_CLK});
    pin_u.pulse(2, 2, 1);
    rdr(IDX_FLAGS);
    `CHK(rd, 8'h08)
    rdr(IDX_CAP_LO);
    `CHK(rd > 8'h00 && rd < 8'h20, 1'b1)
    wr(IDX_CAP_SRC, 8'h01);
    wr(IDX_FLAGS, 8'hFF);
    pin_u.pulse(2, 2, 1);
    rdr(IDX_FLAGS);
    `CHK(rd[BIT_CAPT], 1'b0)
    pin_u.pulse(3, 2, 1);
    rdr(IDX_FLAGS);
    `CHK(rd[BIT_CAPT], 1'b1)
    wr(IDX_WCTL_B, {2'h3, 3'h0, CS_CLK});
    wr(IDX_FLAGS, 8'hFF);
    pin_u.pulse(3, 2, 1);
    rdr(IDX_FLAGS);
    `CHK(rd[BIT_CAPT], 1'b0)
    pin_u.pulse(3, 8, 1);
    rdr(IDX_FLAGS);
    `CHK(rd[BIT_CAPT], 1'b1)
    wr(IDX_WCTL_B, 8'h00);
  endtask : t_cap

  initial
  begin
    repeat (60000) @(posedge pclk);
    failures++;
    results();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ext();
    t_presc();
    t_ovf();
    t_cmp();
    t_pwm();
    t_cap();
    results();
  end
endmodule : dual_timer_counter_unit_tb_top

//--- rtl/dtcu_pkg.sv
// Summary of operation
// [R01] One 8-bit and one 16-bit counter
// [R02] Shared 10-bit prescaler, independent tap choice
// [R03] Taps divide by 1, 8, 64, 256, 1024
// [R04] Narrow counter: clock, prescaled, pin, stopped
// [R05] Wide counter offers same clock sources
// [R06] External count pin synchronised to system clock
// [R07] Pin source keeps one period between edges
// [R08] Narrow overflow flag and enable shared
// [R09] Flag order: wide ovf, A, B, capture, narrow
// [R10] Mask enables aligned with flag positions
// [R11] Wide count compared with A and B
// [R12] Optional clear on compare A match
// [R13] Compare match applies configured pin action
// [R14] Control A: two actions, PWM resolution
// [R15] PWM resolution of 8, 9 or 10 bits
// [R16] Two glitch-free centred PWM outputs
// [R17] Capture copies count, sets capture flag
// [R18] Comparator selectable as capture trigger
// [R19] Control B: cancel, edge, clear, clock select
// [R20] Wide values accessed as high and low bytes
// [R21] Clock select codes: stop, clk, taps, edges
// [R22] Interrupt while flag and enable; write-one clears
package dtcu_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [5:0] IDX_CAP_LO = 6'h24;
  localparam logic [5:0] IDX_CAP_HI = 6'h25;
  localparam logic [5:0] IDX_CMPB_LO = 6'h28;
  localparam logic [5:0] IDX_CMPB_HI = 6'h29;
  localparam logic [5:0] IDX_CMPA_LO = 6'h2A;
  localparam logic [5:0] IDX_CMPA_HI = 6'h2B;
  localparam logic [5:0] IDX_WCNT_LO = 6'h2C;
  localparam logic [5:0] IDX_WCNT_HI = 6'h2D;
  localparam logic [5:0] IDX_WCTL_B = 6'h2E;
  localparam logic [5:0] IDX_WCTL_A = 6'h2F;
  localparam logic [5:0] IDX_CAP_SRC = 6'h30;
  localparam logic [5:0] IDX_NCNT = 6'h32;
  localparam logic [5:0] IDX_NCTL = 6'h33;
  localparam logic [5:0] IDX_FLAGS = 6'h38;
  localparam logic [5:0] IDX_MASK = 6'h39;
  // Flag and mask bit positions
  localparam int BIT_WIDE_OVF = 7;
  localparam int BIT_CMPA = 6;
  localparam int BIT_CMPB = 5;
  localparam int BIT_CAPT = 3;
  localparam int BIT_NARROW_OVF = 1;
  localparam logic [7:0] FLAG_USED = 8'hEA;
  // Control B bit positions
  localparam int BIT_NOISE_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_CLR_ON_A = 3;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CLK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // PWM tops
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Samples that must agree before the capture filter moves
  localparam int NOISE_SAMPLES = 4;
endpackage : dtcu_pkg

//--- rtl/dtcu_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with edge pulses from the synchronised level
module dtcu_sync
  import dtcu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in; // see [R06]
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : dtcu_sync

//--- rtl/dtcu_top.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module dtcu_top
  import dtcu_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic narrow_count_pin,
  input wire logic wide_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_in,
  output logic compare_a_out,
  output logic compare_b_out,
  output logic irq
);
  default clocking ast_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus handshake
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] rd_byte;
  wire [5:0] idx = paddr[7:2];
  wire acc = psel & penable & ~pready_q;
  wire wr_go = psel & penable & pready_q & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire hit = (idx == IDX_CAP_LO) | (idx == IDX_CAP_HI) |
             (idx == IDX_CMPB_LO) | (idx == IDX_CMPB_HI) |
             (idx == IDX_CMPA_LO) | (idx == IDX_CMPA_HI) |
             (idx == IDX_WCNT_LO) | (idx == IDX_WCNT_HI) |
             (idx == IDX_WCTL_B) | (idx == IDX_WCTL_A) |
             (idx == IDX_CAP_SRC) | (idx == IDX_NCNT) |
             (idx == IDX_NCTL) | (idx == IDX_FLAGS) | (idx == IDX_MASK);

  // Software state
  logic [2:0] ncs_q;
  logic [7:0] ncnt_q;
  logic [7:0] wctl_a_q;
  logic [7:0] wctl_b_q;
  logic [15:0] wcnt_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [15:0] cmpa_act_q;
  logic [15:0] cmpb_act_q;
  logic [15:0] cap_q;
  logic cap_src_q;
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic down_q;
  logic oca_q;
  logic ocb_q;
  logic irq_q;
  logic [9:0] pre_q;

  // Write decode
  wire w_ncnt = wr_go & (idx == IDX_NCNT);
  wire w_wcnt_lo = wr_go & (idx == IDX_WCNT_LO);
  wire w_wcnt_hi = wr_go & (idx == IDX_WCNT_HI);
  wire w_wcnt = w_wcnt_lo | w_wcnt_hi;
  wire w_flags = wr_go & (idx == IDX_FLAGS);

  // Control fields
  wire [1:0] act_a = wctl_a_q[7:6]; // see [R14]
  wire [1:0] act_b = wctl_a_q[5:4]; // see [R14]
  wire [1:0] pwm_sel = wctl_a_q[1:0]; // see [R14]
  wire noise_en = wctl_b_q[BIT_NOISE_EN]; // see [R19]
  wire edge_sel = wctl_b_q[BIT_EDGE_SEL]; // see [R19]
  wire clr_on_a = wctl_b_q[BIT_CLR_ON_A]; // see [R19]
  wire [2:0] wcs = wctl_b_q[2:0]; // see [R19]
  wire pwm_on = (pwm_sel != 2'h0);

  // Synchronised pins
  logic n_rise, n_fall;
  logic w_lvl, w_rise, w_fall;
  logic c_lvl, a_lvl;

  dtcu_sync u_sync_n (.pclk(pclk), .presetn(presetn),
    .pin_in(narrow_count_pin), .level(), .rise(n_rise),
    .fall(n_fall));
  dtcu_sync u_sync_w (.pclk(pclk), .presetn(presetn),
    .pin_in(wide_count_pin), .level(w_lvl), .rise(w_rise),
    .fall(w_fall));
  dtcu_sync u_sync_c (.pclk(pclk), .presetn(presetn),
    .pin_in(capture_pin), .level(c_lvl), .rise(), .fall());
  dtcu_sync u_sync_a (.pclk(pclk), .presetn(presetn),
    .pin_in(comparator_in), .level(a_lvl), .rise(), .fall());

  // One shared prescaler, taps picked per counter
  wire tap8 = &pre_q[2:0]; // see [R02]
  wire tap64 = &pre_q[5:0]; // see [R03]
  wire tap256 = &pre_q[7:0]; // see [R03]
  wire tap1024 = &pre_q; // see [R03]

  function automatic logic pick_tick(input logic [2:0] cs,
    input logic t8, input logic t64, input logic t256,
    input logic t1024, input logic er, input logic ef);
    logic t;
    t = 1'b0;
    case (cs) // see [R21]
      CS_STOP: t = 1'b0;
      CS_CLK: t = 1'b1;
      CS_DIV8: t = t8;
      CS_DIV64: t = t64;
      CS_DIV256: t = t256;
      CS_DIV1024: t = t1024;
      CS_EXT_FALL: t = ef;
      CS_EXT_RISE: t = er;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : pick_tick

  wire n_tick = pick_tick(ncs_q, tap8, tap64, tap256, tap1024,
                          n_rise, n_fall); // see [R04]
  wire w_tick = pick_tick(wcs, tap8, tap64, tap256, tap1024,
                          w_rise, w_fall); // see [R05]

  // Narrow counter overflow
  wire n_ovf = n_tick & (ncnt_q == 8'hFF); // see [R08]

  // Wide counter next value
  logic [15:0] top;
  always_comb
  begin
    case (pwm_sel) // see [R15]
      2'h1: top = TOP_8;
      2'h2: top = TOP_9;
      2'h3: top = TOP_10;
      default: top = 16'hFFFF;
    endcase
  end

  wire match_a = w_tick & (wcnt_q == cmpa_act_q); // see [R11]
  wire match_b = w_tick & (wcnt_q == cmpb_act_q); // see [R11]
  wire at_top = pwm_on & ~down_q & (wcnt_q >= top);
  wire at_bot = pwm_on & down_q & (wcnt_q == 16'h0000);
  wire w_ovf = w_tick & (pwm_on ? at_bot : (wcnt_q == 16'hFFFF));

  logic [15:0] wcnt_d;
  logic down_d;
  always_comb
  begin
    wcnt_d = wcnt_q;
    down_d = down_q;
    if (w_tick)
    begin
      if (pwm_on)
      begin
        // Count up to top then back down to zero
        if (at_top)
        begin
          down_d = 1'b1;
          wcnt_d = wcnt_q - 16'h0001;
        end
        else if (at_bot)
        begin
          down_d = 1'b0;
          wcnt_d = 16'h0001;
        end
        else if (down_q)
          wcnt_d = wcnt_q - 16'h0001;
        else
          wcnt_d = wcnt_q + 16'h0001;
      end
      else if (clr_on_a && match_a)
        wcnt_d = RST_WORD; // see [R12]
      else
        wcnt_d = wcnt_q + 16'h0001;
    end
    if (!pwm_on)
      down_d = 1'b0;
    if (w_wcnt_lo)
      wcnt_d = {wcnt_q[15:8], wb}; // see [R20]
    if (w_wcnt_hi)
      wcnt_d = {wb, wcnt_q[7:0]}; // see [R20]
  end

  // Output pin action for one channel
  function automatic logic oc_next(input logic [1:0] act,
    input logic pwm, input logic dn, input logic cur);
    logic v;
    v = cur;
    if (pwm)
    begin
      // Clear on the way up, set on the way down: centred pulse
      if (act == ACT_CLEAR)
        v = dn;
      else if (act == ACT_SET)
        v = ~dn;
    end
    else
    begin
      case (act)
        ACT_TOGGLE: v = ~cur;
        ACT_CLEAR: v = 1'b0;
        ACT_SET: v = 1'b1;
        default: v = cur;
      endcase
    end
    return v;
  endfunction : oc_next

  // Capture path with optional noise filter
  logic [NOISE_SAMPLES-1:0] samp_q;
  logic filt_q;
  logic filt_prev_q;
  wire cap_raw = cap_src_q ? a_lvl : c_lvl; // see [R18]
  wire all_hi = &samp_q;
  wire all_lo = ~|samp_q;
  wire cap_lvl = noise_en ? filt_q : samp_q[0];
  wire cap_evt = edge_sel ? (cap_lvl & ~filt_prev_q)
                          : (~cap_lvl & filt_prev_q); // see [R17]

  wire [7:0] flag_set = {w_ovf, match_a, match_b, 1'b0, cap_evt,
                         1'b0, n_ovf, 1'b0}; // see [R09]
  wire [7:0] flag_clr = w_flags ? (wb & FLAG_USED) : 8'h00;
  // A set in the clearing cycle wins
  wire [7:0] flags_d = ((flags_q & ~flag_clr) | flag_set)
                       & FLAG_USED; // see [R22]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 10'h000;
      ncnt_q <= RST_BYTE;
      wcnt_q <= RST_WORD;
      down_q <= 1'b0;
      flags_q <= RST_BYTE;
      oca_q <= 1'b0;
      ocb_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + 10'h001; // see [R02]
      if (w_ncnt)
        ncnt_q <= wb;
      else if (n_tick)
        ncnt_q <= ncnt_q + 8'h01; // see [R01]
      wcnt_q <= wcnt_d; // see [R01]
      down_q <= down_d;
      flags_q <= flags_d; // see [R08]
      if (match_a)
        oca_q <= oc_next(act_a, pwm_on, down_q, oca_q); // see [R13]
      if (match_b)
        ocb_q <= oc_next(act_b, pwm_on, down_q, ocb_q); // see [R16]
      irq_q <= |(flags_q & mask_q); // see [R22]
    end
  end

  // Compare buffers reload at top in PWM so a pulse is never cut
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmpa_act_q <= RST_WORD;
      cmpb_act_q <= RST_WORD;
    end
    else if (!pwm_on || (w_tick && at_top))
    begin
      cmpa_act_q <= cmpa_q; // see [R16]
      cmpb_act_q <= cmpb_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_q <= '0;
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
      cap_q <= RST_WORD;
    end
    else
    begin
      samp_q <= {samp_q[NOISE_SAMPLES-2:0], cap_raw};
      if (all_hi)
        filt_q <= 1'b1; // see [R19]
      else if (all_lo)
        filt_q <= 1'b0;
      filt_prev_q <= cap_lvl;
      if (cap_evt)
        cap_q <= wcnt_q; // see [R17]
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ncs_q <= 3'h0;
      wctl_a_q <= RST_BYTE;
      wctl_b_q <= RST_BYTE;
      cmpa_q <= RST_WORD;
      cmpb_q <= RST_WORD;
      cap_src_q <= 1'b0;
      mask_q <= RST_BYTE;
    end
    else if (wr_go)
    begin
      case (idx)
        IDX_NCTL: ncs_q <= wb[2:0];
        IDX_WCTL_A: wctl_a_q <= wb & 8'hF3;
        IDX_WCTL_B: wctl_b_q <= wb & 8'hCF;
        IDX_CMPA_LO: cmpa_q[7:0] <= wb; // see [R20]
        IDX_CMPA_HI: cmpa_q[15:8] <= wb;
        IDX_CMPB_LO: cmpb_q[7:0] <= wb;
        IDX_CMPB_HI: cmpb_q[15:8] <= wb;
        IDX_CAP_SRC: cap_src_q <= wb[0];
        IDX_MASK: mask_q <= wb & FLAG_USED; // see [R10]
        default: ;
      endcase
    end
  end

  // Read selection
  always_comb
  begin
    case (idx)
      IDX_CAP_LO: rd_byte = cap_q[7:0];
      IDX_CAP_HI: rd_byte = cap_q[15:8];
      IDX_CMPB_LO: rd_byte = cmpb_q[7:0];
      IDX_CMPB_HI: rd_byte = cmpb_q[15:8];
      IDX_CMPA_LO: rd_byte = cmpa_q[7:0];
      IDX_CMPA_HI: rd_byte = cmpa_q[15:8];
      IDX_WCNT_LO: rd_byte = wcnt_q[7:0];
      IDX_WCNT_HI: rd_byte = wcnt_q[15:8];
      IDX_WCTL_B: rd_byte = wctl_b_q;
      IDX_WCTL_A: rd_byte = wctl_a_q;
      IDX_CAP_SRC: rd_byte = {7'h00, cap_src_q};
      IDX_NCNT: rd_byte = ncnt_q;
      IDX_NCTL: rd_byte = {5'h00, ncs_q};
      IDX_FLAGS: rd_byte = flags_q;
      IDX_MASK: rd_byte = mask_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: pready rises the cycle after penable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit;
      if (acc && !pwrite)
        prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign compare_a_out = oca_q;
  assign compare_b_out = ocb_q;
  assign irq = irq_q;

  AST_NARROW_OVF: assert property ( // see [R08]
    (n_tick && ncnt_q == 8'hFF && !w_ncnt) |=>
    (flags_q[BIT_NARROW_OVF] && ncnt_q == 8'h00))
    else $error("narrow overflow not flagged");
  AST_NARROW_STOP: assert property ( // see [R04]
    (ncs_q == CS_STOP && !w_ncnt) |=> $stable(ncnt_q))
    else $error("stopped narrow counter moved");
  AST_WIDE_STOP: assert property ( // see [R05]
    (wcs == CS_STOP && !w_wcnt) |=> $stable(wcnt_q))
    else $error("stopped wide counter moved");
  AST_DIV64: assert property ( // see [R03]
    (ncs_q == CS_DIV64 && n_tick) |-> (pre_q[5:0] == 6'h3F))
    else $error("narrow tick off the divide-by-64 tap");
  AST_EXT_RISE: assert property ( // see [R06]
    (wcs == CS_EXT_RISE && w_tick) |-> (w_lvl && !$past(w_lvl)))
    else $error("wide tick without synchronised rising edge");
  AST_CLR_ON_A: assert property ( // see [R12]
    (!pwm_on && clr_on_a && match_a && !w_wcnt) |=>
    (wcnt_q == 16'h0000 && flags_q[BIT_CMPA]))
    else $error("compare A did not clear the counter");
  AST_PWM_TURN: assert property ( // see [R15]
    (w_tick && at_top && !w_wcnt) |=>
    (down_q && wcnt_q == $past(wcnt_q) - 16'h0001))
    else $error("PWM did not turn at top");
  AST_PWM_PIN: assert property ( // see [R16]
    (pwm_on && act_a == ACT_CLEAR && match_a) |=>
    (oca_q == $past(down_q)))
    else $error("PWM compare A pin wrong");
  AST_CAPTURE: assert property ( // see [R17]
    cap_evt |=> (cap_q == $past(wcnt_q) && flags_q[BIT_CAPT]))
    else $error("capture missed the count");
  AST_IRQ: assert property ( // see [R22]
    (|(flags_q & mask_q)) |=> irq_q)
    else $error("interrupt not raised");
  AST_FLAG_CLR: assert property ( // see [R22]
    (w_flags && wb[BIT_CMPB] && !match_b) |=> !flags_q[BIT_CMPB])
    else $error("write one did not clear compare B flag");
  AST_APB_WAIT: assert property (
    (psel && !penable) ##1 (psel && penable) |-> !pready_q ##1 pready_q)
    else $error("access did not complete after one wait");
endmodule : dtcu_top
